// file: rtl/io_interrupt_bus_arbiter.sv
// Purpose: Gathers 24 interrupt inputs and wins the shared interrupt bus.
// Assumes: vector_table and route selects are static configuration;
//          frame_* come from the message sender on the bus clock.
// Notes:   Core on mclk, arbitration on interrupt_bus_clock.
// Contract
// - Twenty-four inputs, each with programmed vector
// - Priority follows vector, not input number
// - Cascade, timer, clock, FPU on fixed inputs
// - Delivery by bus message, no acknowledge
// - Win arbitration before any message
// - Open-drain lines; line 1 arbitrates
// - Bus logic on dedicated bus clock
// - Winner takes identifier zero
// - Losers increment; fifteen takes winner plus one
// - Rotate only after good, non-lowest message
// - End-of-interrupt requests beat normal ones
// - Idle and pending: pull line 0 low
// - Line 1 low at start: back off
// - Cycles 2-5 send identifier MSB first
// - Released but low: lost, stop driving
// - Normal request leaves line 1 high
// - After cycle 5 winner owns bus
`timescale 1ns/10ps
`include "ioint_regs.svh"
module io_interrupt_bus_arbiter (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [23:0]          irq_ext,
  input  wire logic                 cascade_irq,
  input  wire logic                 timer0_irq,
  input  wire logic                 rtc_irq,
  input  wire logic                 fpu_error_input,
  input  wire logic                 acpi_event_interrupt,
  input  wire logic                 timer_watchdog_event,
  input  wire ioint_pkg::route_e    acpi_route,
  input  wire ioint_pkg::route_e    watchdog_route,
  input  wire logic [23:0][7:0]     vector_table,
  input  wire logic                 interrupt_bus_clock,
  input  wire logic                 bus_d0_i,
  output logic                      bus_d0_o,
  output logic                      bus_d0_oe,
  input  wire logic                 bus_d1_i,
  output logic                      bus_d1_o,
  output logic                      bus_d1_oe,
  output logic                      start_of_message,
  output ioint_pkg::msg_s           message,
  input  wire logic                 frame_done,
  input  wire logic                 frame_ok,
  input  wire logic                 frame_lowpri,
  output logic [3:0]                arbitration_identifier
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int NSRC = `IOINT_NUM_INPUTS + 6;
  logic [NSRC-1:0] raw;                  // All asynchronous sources
  logic [NSRC-1:0] sync1;                // First stage, read by sync2 only
  logic [NSRC-1:0] sync2;                // Safe copy

  assign raw = {timer_watchdog_event, acpi_event_interrupt, fpu_error_input,
                rtc_irq, timer0_irq, cascade_irq, irq_ext};

  // Two flops per source bit
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Source mapping
  // One-hot target of a routing choice
  function automatic logic [23:0] route_mask(input ioint_pkg::route_e r);
    logic [23:0] m;
    m = 24'h00_0000;
    case (r)
      ioint_pkg::ROUTE_A: m = 24'h00_0001 << `IOINT_IDX_ROUTE_A;
      ioint_pkg::ROUTE_B: m = 24'h00_0001 << `IOINT_IDX_ROUTE_B;
      ioint_pkg::ROUTE_C: m = 24'h00_0001 << `IOINT_IDX_ROUTE_C;
      ioint_pkg::ROUTE_D: m = 24'h00_0001 << `IOINT_IDX_ROUTE_D;
      ioint_pkg::ROUTE_E: m = 24'h00_0001 << `IOINT_IDX_ROUTE_E;
      default:            m = 24'h00_0000;
    endcase
    return m;
  endfunction : route_mask

  logic [23:0] src;                      // Assembled input levels
  // Internal sources override their fixed slots
  always_comb begin
    src = sync2[23:0];
    src[`IOINT_IDX_CASCADE] = sync2[24];
    src[`IOINT_IDX_TIMER0]  = sync2[25];
    src[`IOINT_IDX_RTC]     = sync2[26];
    src[`IOINT_IDX_FPU]     = sync2[27];
    src = src | (route_mask(acpi_route) & {24{sync2[28]}});
    src = src | (route_mask(watchdog_route) & {24{sync2[29]}});
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending latch and selection
  logic [23:0]               src_q;       // Previous levels
  logic [23:0]               pend;        // Edges awaiting delivery
  logic [23:0]               next_pend;
  ioint_pkg::core_state_e    cstate;
  ioint_pkg::core_state_e    next_cstate;
  ioint_pkg::req_s           req_d;       // Held while req is high
  ioint_pkg::req_s           next_req_d;
  logic                      req;         // Handshake request
  logic                      next_req;
  logic                      ack_s1;      // Ack first stage
  logic                      ack_s2;      // Ack safe copy
  logic                      ack;         // Link side delivery ack
  logic                      sel_any;
  logic [4:0]                sel_idx;
  logic [7:0]                sel_vec;
  logic [23:0]               clr;

  // Highest programmed vector wins, whatever its input number
  always_comb begin
    sel_any = 1'b0;
    sel_idx = 5'h00;
    sel_vec = 8'h00;
    for (int i = 0; i < `IOINT_NUM_INPUTS; i++) begin
      if (pend[i] && (!sel_any || vector_table[i] > sel_vec)) begin
        sel_any = 1'b1;
        sel_idx = 5'(i);
        sel_vec = vector_table[i];
      end
    end
  end

  // Request sequencer and pending update
  always_comb begin
    next_cstate = cstate;
    next_req    = req;
    next_req_d  = req_d;
    clr         = 24'h00_0000;
    case (cstate)
      ioint_pkg::C_IDLE: begin
        if (sel_any) begin
          next_req_d  = '{irq: sel_idx, vector: sel_vec};
          next_req    = 1'b1;
          next_cstate = ioint_pkg::C_REQ;
        end
      end
      ioint_pkg::C_REQ: begin
        if (ack_s2) begin
          clr         = 24'h00_0001 << req_d.irq;
          next_req    = 1'b0;
          next_cstate = ioint_pkg::C_DROP;
        end
      end
      ioint_pkg::C_DROP: begin
        if (!ack_s2) begin
          next_cstate = ioint_pkg::C_IDLE;
        end
      end
      default: next_cstate = ioint_pkg::C_IDLE;
    endcase
    // A new edge wins over a clear in the same cycle
    next_pend = (pend & ~clr) | (src & ~src_q);
  end

  // Core registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_q  <= 24'h00_0000;
      pend   <= 24'h00_0000;
      cstate <= ioint_pkg::C_IDLE;
      req    <= 1'b0;
      req_d  <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      src_q  <= src;
      pend   <= next_pend;
      cstate <= next_cstate;
      req    <= next_req;
      req_d  <= next_req_d;
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
    end
  end

  prio_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cstate == ioint_pkg::C_IDLE && sel_any) |=> req &&
      req_d.vector == $past(sel_vec) && $past(pend[sel_idx]))
    else $error("request not the highest vector");

  ////////////////////////////////////////////////////////////////////////
  // Bus clock domain
  logic                      lrst1;       // Reset release first stage
  logic                      lrst_n;      // Link reset, sync release
  logic                      req_l1;      // Req first stage
  logic                      req_l2;      // Req safe copy
  ioint_pkg::link_state_e    state;
  ioint_pkg::link_state_e    next_state;
  logic                      d0_drv, next_d0_drv;
  logic                      d1_drv, next_d1_drv;
  logic                      busy, next_busy;       // Frame in progress
  logic [2:0]                cyc, next_cyc;         // Current bus cycle
  logic                      idle_ok, next_idle_ok; // Both lines seen high
  logic [3:0]                win_id, next_win_id;   // Observed winner id
  logic [3:0]                arb_id, next_arb_id;
  logic                      next_ack;
  logic                      next_sof;
  ioint_pkg::msg_s           next_msg;
  logic                      rotate;
  logic                      exp_bit;

  // Reset released on the bus clock
  always_ff @(posedge interrupt_bus_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst1  <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst1  <= 1'b1;
      lrst_n <= lrst1;
    end
  end

  assign rotate  = frame_done && frame_ok && !frame_lowpri;
  assign exp_bit = arb_id[2'(3'h5 - cyc)];

  // Bus observer and arbitration sequencer
  always_comb begin
    next_state   = state;
    next_d0_drv  = d0_drv;
    next_d1_drv  = d1_drv;
    next_busy    = busy;
    next_cyc     = cyc;
    next_idle_ok = idle_ok;
    next_win_id  = win_id;
    next_arb_id  = arb_id;
    next_ack     = ack;
    next_sof     = 1'b0;
    next_msg     = message;
    // Lines are synchronous to this clock: sampled directly
    if (!busy) begin
      if (!bus_d0_i) begin
        next_busy    = 1'b1;
        next_cyc     = `IOINT_ARB_FIRST;
        next_idle_ok = 1'b0;
      end else if (bus_d1_i) begin
        next_idle_ok = 1'b1;
      end
    end else if (cyc >= `IOINT_ARB_FIRST && cyc <= `IOINT_ARB_LAST) begin
      next_win_id = {win_id[2:0], ~bus_d1_i};
      next_cyc    = cyc + 3'h1;
    end
    if (frame_done) begin
      next_busy = 1'b0;
      next_cyc  = 3'h0;
      if (rotate) begin
        if (state == ioint_pkg::L_OWN) begin
          next_arb_id = `IOINT_ARBITRATION_IDENTIFIER_WIN;
        end else if (arb_id == `IOINT_ARBITRATION_IDENTIFIER_MAX) begin
          next_arb_id = win_id + 4'h1;
        end else begin
          next_arb_id = arb_id + 4'h1;
        end
      end
    end
    case (state)
      ioint_pkg::L_IDLE: begin
        if (req_l2 && !ack && idle_ok && !busy && bus_d0_i) begin
          next_d0_drv = 1'b1;
          next_state  = ioint_pkg::L_ARB;
        end
      end
      ioint_pkg::L_ARB: begin
        next_d0_drv = 1'b0;
        if (!busy) begin
          if (!bus_d1_i) begin
            next_d1_drv = 1'b0;
            next_state  = ioint_pkg::L_LOST;
          end else begin
            next_d1_drv = arb_id[3];
          end
        end else if (!d1_drv && !bus_d1_i) begin
          next_d1_drv = 1'b0;
          next_state  = ioint_pkg::L_LOST;
        end else if (cyc == `IOINT_ARB_LAST) begin
          next_d1_drv = 1'b0;
          next_state  = ioint_pkg::L_OWN;
          next_sof    = 1'b1;
          next_msg    = '{irq: req_d.irq, vector: req_d.vector, arb_id: arb_id};
        end else begin
          next_d1_drv = arb_id[2'(3'h4 - cyc)];
        end
      end
      ioint_pkg::L_LOST: begin
        if (frame_done) begin
          next_state = ioint_pkg::L_IDLE;
        end
      end
      ioint_pkg::L_OWN: begin
        if (frame_done) begin
          next_ack   = frame_ok;
          next_state = ioint_pkg::L_IDLE;
        end
      end
      default: next_state = ioint_pkg::L_IDLE;
    endcase
    if (!req_l2) begin
      next_ack = 1'b0;
    end
  end

  // Link registers; req_d is stable while req is high
  always_ff @(posedge interrupt_bus_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      req_l1           <= 1'b0;
      req_l2           <= 1'b0;
      state            <= ioint_pkg::L_IDLE;
      d0_drv           <= 1'b0;
      d1_drv           <= 1'b0;
      busy             <= 1'b0;
      cyc              <= 3'h0;
      idle_ok          <= 1'b0;
      win_id           <= 4'h0;
      arb_id           <= `IOINT_ARBITRATION_IDENTIFIER_RESET;
      ack              <= 1'b0;
      start_of_message <= 1'b0;
      message          <= '0;
    end else begin
      req_l1           <= req;
      req_l2           <= req_l1;
      state            <= next_state;
      d0_drv           <= next_d0_drv;
      d1_drv           <= next_d1_drv;
      busy             <= next_busy;
      cyc              <= next_cyc;
      idle_ok          <= next_idle_ok;
      win_id           <= next_win_id;
      arb_id           <= next_arb_id;
      ack              <= next_ack;
      start_of_message <= next_sof;
      message          <= next_msg;
    end
  end

  // Open-drain: only ever pull low
  assign bus_d0_o  = 1'b0;
  assign bus_d0_oe = d0_drv;
  assign bus_d1_o  = 1'b0;
  assign bus_d1_oe = d1_drv;
  assign arbitration_identifier = arb_id;

  start_drive_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    (state == ioint_pkg::L_IDLE && next_state == ioint_pkg::L_ARB) |=> bus_d0_oe ##1 !bus_d0_oe)
    else $error("start cycle not one cycle of line 0 low");
  idle_start_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    $rose(d0_drv) |-> $past(idle_ok) && !$past(busy))
    else $error("start without idle bus");
  normal_req_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    bus_d0_oe |-> !bus_d1_oe)
    else $error("line 1 pulled in start cycle");
  eoi_backoff_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    (state == ioint_pkg::L_ARB && !busy && !bus_d1_i) |=>
      state == ioint_pkg::L_LOST && !bus_d0_oe && !bus_d1_oe)
    else $error("no back-off on end-of-interrupt start");
  id_bits_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    (state == ioint_pkg::L_ARB && busy) |-> bus_d1_oe == exp_bit && !bus_d0_oe)
    else $error("identifier bit wrong on line 1");
  loss_release_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    (state == ioint_pkg::L_ARB && busy && !d1_drv && !bus_d1_i) |=>
      (!bus_d1_oe && !bus_d0_oe && !start_of_message) [*2])
    else $error("drive kept after lost arbitration");
  sof_after5_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    start_of_message |-> $past(state) == ioint_pkg::L_ARB && $past(cyc) == 3'h5)
    else $error("message start not after cycle 5");
  win_reset_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    (rotate && state == ioint_pkg::L_OWN) |=> arb_id == 4'h0)
    else $error("winner identifier not cleared");
  wrap_id_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    (rotate && state != ioint_pkg::L_OWN && arb_id == 4'hf) |=> arb_id == $past(win_id) + 4'h1)
    else $error("identifier fifteen not moved to winner plus one");
  no_rotate_a: assert property (@(posedge interrupt_bus_clock) disable iff (!lrst_n)
    !rotate |=> $stable(arb_id))
    else $error("identifier moved without a good message");
endmodule : io_interrupt_bus_arbiter

// file: rtl/ioint_regs.svh
// Purpose: Constants for the I/O interrupt bus arbiter.
// Assumes: Included by bare name; definitions only.
// Notes:   Input indices, arbitration cycle numbers and identifier values.
`ifndef IOINT_REGS_SVH
`define IOINT_REGS_SVH
`define IOINT_NUM_INPUTS 24
// Fixed internal source positions
`define IOINT_IDX_CASCADE 5'h00
`define IOINT_IDX_TIMER0 5'h02
`define IOINT_IDX_RTC 5'h08
`define IOINT_IDX_FPU 5'h0d
// Optional routing targets for event interrupts
`define IOINT_IDX_ROUTE_A 5'h09
`define IOINT_IDX_ROUTE_B 5'h0a
`define IOINT_IDX_ROUTE_C 5'h0b
`define IOINT_IDX_ROUTE_D 5'h16
`define IOINT_IDX_ROUTE_E 5'h17
// Arbitration cycle numbers on the interrupt bus
`define IOINT_ARB_FIRST 3'h2
`define IOINT_ARB_LAST 3'h5
// Arbitration identifier values
`define IOINT_ARBITRATION_IDENTIFIER_WIN 4'h0
`define IOINT_ARBITRATION_IDENTIFIER_MAX 4'hf
`define IOINT_ARBITRATION_IDENTIFIER_RESET 4'h0
// Interrupt bus clock period, 16.6667 MHz
`define IOINT_BUSCLK_PERIOD_PS 60000
`endif

// file: rtl/ioint_pkg.sv
// Purpose: Types for the I/O interrupt bus arbiter.
// Assumes: Used by scoped names only.
// Notes:   Routing choices, state enums and carrier structs.
package ioint_pkg;
  // Where an event interrupt is steered
  typedef enum logic [2:0] {ROUTE_OFF, ROUTE_A, ROUTE_B, ROUTE_C, ROUTE_D, ROUTE_E} route_e;
  // Core side request sequencer
  typedef enum logic [1:0] {C_IDLE, C_REQ, C_DROP} core_state_e;
  // Link side arbitration sequencer
  typedef enum logic [1:0] {L_IDLE, L_ARB, L_LOST, L_OWN} link_state_e;
  // Request handed from core to link
  typedef struct packed {
    logic [4:0] irq;
    logic [7:0] vector;
  } req_s;
  // Message handed to the message sender after a win
  typedef struct packed {
    logic [4:0] irq;
    logic [7:0] vector;
    logic [3:0] arb_id;
  } msg_s;
endpackage : ioint_pkg

// file: tb/bus_agent_model.sv
// Purpose: Far-side agent on the three-wire interrupt bus, plus frame timing.
// Assumes: Acts 1 ns after each rising bus clock edge; lines resolved outside.
// Notes:   Reports status of every frame, whoever won it.
`timescale 1ns/10ps
module bus_agent_model #(
  parameter int FLEN = 21                // Frame length in bus cycles
) (
  input  wire logic bclk,                // Bus clock
  input  wire logic d0,                  // Resolved line 0
  input  wire logic d1,                  // Resolved line 1
  input  wire logic st_ok,               // Status to report at frame end
  input  wire logic st_lowpri,           // Lowest-priority frame type
  output logic      d0_oe,               // High pulls line 0 low
  output logic      d1_oe,               // High pulls line 1 low
  output logic      frame_done,          // One-cycle end of frame
  output logic      frame_ok,            // Valid with frame_done
  output logic      frame_lowpri         // Valid with frame_done
);
  logic       armed;                     // Request waiting
  logic       join_only;                 // Start only beside another start
  logic       eoi;                       // End-of-interrupt request
  logic [3:0] id;                        // Identifier to send
  logic       mine;                      // Still in arbitration
  logic       s1;                        // Line 1 at end of last cycle
  int         cyc;                       // Frame cycle, 0 when idle

  ////////////////////////////////////////////////////////////////////////////
  // Hand the agent one request
  task automatic arm(input logic e, input logic [3:0] i, input logic j);
    eoi       = e;
    id        = i;
    join_only = j;
    armed     = 1'b1;
  endtask : arm

  ////////////////////////////////////////////////////////////////////////////
  // Cycle engine on the bus clock
  initial begin
    d0_oe      = 1'b0;
    d1_oe      = 1'b0;
    frame_done = 1'b0;
    armed      = 1'b0;
    mine       = 1'b0;
    cyc        = 0;
    forever begin
      @(posedge bclk);
      s1 = d1;
      #1;
      frame_done   = 1'b0;
      frame_ok     = ~st_ok;             // Junk outside the pulse
      frame_lowpri = ~st_lowpri;
      if (cyc == 0) begin
        if (armed && (!join_only || !d0)) begin
          d0_oe = 1'b1;
          d1_oe = eoi;
          mine  = 1'b1;
          armed = 1'b0;
          cyc   = 1;
        end else if (!d0) begin          // Someone else opened a frame
          cyc = 1;
        end
      end else begin
        if (mine && !d1_oe && !s1) begin
          mine = 1'b0;
        end
        d0_oe = 1'b0;
        d1_oe = (cyc < 5) ? (mine & id[4 - cyc]) : 1'b0;
        cyc++;
        if (cyc == FLEN) begin
          frame_done   = 1'b1;
          frame_ok     = st_ok;
          frame_lowpri = st_lowpri;
          mine         = 1'b0;
          cyc          = 0;
        end
      end
    end
  end
endmodule : bus_agent_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the interrupt bus arbiter.
// Assumes: One far-side agent model; inputs change at falling mclk.
// Notes:   Expected messages and identifiers queue up; a monitor compares.
`timescale 1ns/10ps
module tb;
  logic                 mclk;            // Core clock
  logic                 bclk;            // Interrupt bus clock
  logic                 rst_n;           // Reset, active low
  logic [23:0]          irq_ext;         // External sources
  logic [5:0]           src;             // Cascade, timer, rtc, fpu, acpi, watchdog
  ioint_pkg::route_e    acpi_route;      // Event routing
  ioint_pkg::route_e    watchdog_route;  // Event routing
  logic [23:0][7:0]     vt;              // Vector per input
  logic                 d0, d1;          // Resolved lines
  logic                 d0_o, d0_oe, d1_o, d1_oe; // Design drivers
  logic                 m0_oe, m1_oe;    // Agent drivers
  logic                 sof;             // Start of message
  ioint_pkg::msg_s      msg;             // Won message
  logic                 fd, fok, flp;    // Frame status
  logic                 st_ok, st_lowpri; // Status the agent reports
  logic [3:0]           arb_id;          // Design identifier
  logic [3:0]           eid;             // Expected identifier
  logic [3:0]           w;               // Agent identifier
  ioint_pkg::msg_s      q_msg[$];        // Expected messages
  logic [3:0]           q_id[$];         // Expected identifier per frame
  int                   n_fail;
  int                   samples_checked;
  int                   dummy, a, b, hi;
  int                   fixed [4] = '{0, 2, 8, 13};
  int                   ridx [6] = '{0, 9, 10, 11, 22, 23};

  assign d0 = ~((d0_oe & ~d0_o) | m0_oe); // Pull-up, wire-OR low
  assign d1 = ~((d1_oe & ~d1_o) | m1_oe);

  always #10 mclk = ~mclk;
  initial begin
    bclk = 1'b0;
    #3.7;
    forever #15 bclk = ~bclk;
  end

  io_interrupt_bus_arbiter dut (.mclk(mclk), .rst_n(rst_n), .irq_ext(irq_ext), .cascade_irq(src[0]),
    .timer0_irq(src[1]), .rtc_irq(src[2]), .fpu_error_input(src[3]), .acpi_event_interrupt(src[4]),
    .timer_watchdog_event(src[5]), .acpi_route(acpi_route), .watchdog_route(watchdog_route),
    .vector_table(vt), .interrupt_bus_clock(bclk), .bus_d0_i(d0), .bus_d0_o(d0_o), .bus_d0_oe(d0_oe),
    .bus_d1_i(d1), .bus_d1_o(d1_o), .bus_d1_oe(d1_oe), .start_of_message(sof), .message(msg),
    .frame_done(fd), .frame_ok(fok), .frame_lowpri(flp), .arbitration_identifier(arb_id));

  bus_agent_model m (.bclk(bclk), .d0(d0), .d1(d1), .st_ok(st_ok), .st_lowpri(st_lowpri),
    .d0_oe(m0_oe), .d1_oe(m1_oe), .frame_done(fd), .frame_ok(fok), .frame_lowpri(flp));

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic cmp_msg(input ioint_pkg::msg_s got, input ioint_pkg::msg_s exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_msg

  task automatic cmp_id(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_id

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: messages at start, identifiers after each frame
  always @(posedge bclk) begin
    if (sof) begin
      cmp_msg(msg, (q_msg.size() != 0) ? q_msg.pop_front() : ioint_pkg::msg_s'('x));
    end
    if (fd) begin
      @(negedge bclk);
      cmp_id(arb_id, (q_id.size() != 0) ? q_id.pop_front() : 4'hx);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  task automatic note_msg(input int idx);
    q_msg.push_back('{irq: 5'(idx), vector: vt[idx], arb_id: eid});
  endtask : note_msg

  task automatic note_frame(input logic ok, input logic lp, input logic ours, input logic [3:0] wid);
    if (ok && !lp) begin
      eid = ours ? 4'h0 : ((eid == 4'hf) ? wid + 4'h1 : eid + 4'h1);
    end
    q_id.push_back(eid);
  endtask : note_frame

  // Wait for all noted frames, then drop every source
  task automatic settle();
    int k;
    k = 0;
    while ((q_msg.size() + q_id.size() != 0) && k < 400) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 400) begin
      n_fail++;
      $display("BAD t=%0t pending %h %h", $time, q_msg.size(), q_id.size());
    end
    repeat (4) @(negedge mclk);
    src     = '0;
    irq_ext = '0;
    repeat (4) @(negedge mclk);
  endtask : settle

  // Frame won by the agent alone
  task automatic other(input logic lp, input logic ok);
    w = 4'($urandom);
    if (w == eid) begin
      w = w + 4'h1;
    end
    st_ok     = ok;
    st_lowpri = lp;
    note_frame(ok, lp, 1'b0, w);
    m.arm(1'b0, w, 1'b0);
    settle();
    st_ok     = 1'b1;
    st_lowpri = 1'b0;
  endtask : other

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #500000;
    n_fail++;
    $display("BAD t=%0t hang %h %h", $time, q_msg.size(), q_id.size());
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    mclk = 1'b0; rst_n = 1'b0; irq_ext = '0; src = '0; eid = 4'h0;
    acpi_route = ioint_pkg::ROUTE_OFF; watchdog_route = ioint_pkg::ROUTE_OFF;
    st_ok = 1'b1; st_lowpri = 1'b0; n_fail = 0; samples_checked = 0;
    dummy = $urandom(32'hfbe9);
    foreach (vt[i]) vt[i] = 8'($urandom);
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    cmp_id(arb_id, 4'h0);
    cmp_id({2'b00, d0_oe, d1_oe}, 4'h0);
    repeat (8) @(negedge mclk);
    foreach (fixed[i]) begin
      note_msg(fixed[i]);
      note_frame(1'b1, 1'b0, 1'b1, 4'h0);
      src[i] = 1'b1;
      settle();
    end
    for (int r = 1; r < 6; r++) begin
      acpi_route     = ioint_pkg::route_e'(r);
      watchdog_route = ioint_pkg::route_e'(6 - r);
      // One event at a time, so each settle only waits for its own frame
      note_msg(ridx[r]);
      note_frame(1'b1, 1'b0, 1'b1, 4'h0);
      src[4] = 1'b1;
      settle();
      note_msg(ridx[6 - r]);
      note_frame(1'b1, 1'b0, 1'b1, 4'h0);
      src[5] = 1'b1;
      settle();
    end
    repeat (4) begin
      a     = 1 + ($urandom % 7);
      a     = (a == 2) ? 3 : a;
      b     = 14 + ($urandom % 8);
      vt[a] = 8'($urandom);
      vt[b] = 8'($urandom);
      hi    = (vt[b] > vt[a]) ? b : a;
      note_msg(hi);
      note_frame(1'b1, 1'b0, 1'b1, 4'h0);
      note_msg(a + b - hi);
      note_frame(1'b1, 1'b0, 1'b1, 4'h0);
      irq_ext[a] = 1'b1;
      irq_ext[b] = 1'b1;
      settle();
    end
    st_ok = 1'b0;
    note_msg(5);
    note_frame(1'b0, 1'b0, 1'b1, 4'h0);
    note_msg(5);
    note_frame(1'b1, 1'b0, 1'b1, 4'h0);
    irq_ext[5] = 1'b1;
    @(posedge bclk iff fd);
    @(negedge bclk);
    st_ok = 1'b1;
    settle();
    while (eid != 4'hf) other(1'b0, 1'b1);
    other(1'b1, 1'b1);
    other(1'b0, 1'b0);
    other(1'b0, 1'b1);
    m.arm(1'b0, eid - 4'h1, 1'b1);
    note_msg(7);
    note_frame(1'b1, 1'b0, 1'b1, 4'h0);
    @(negedge mclk);
    irq_ext[7] = 1'b1;
    settle();
    w = 4'($urandom);
    m.arm(1'b1, w, 1'b1);
    note_frame(1'b1, 1'b0, 1'b0, w);
    note_msg(9);
    note_frame(1'b1, 1'b0, 1'b1, 4'h0);
    irq_ext[9] = 1'b1;
    settle();
    w = 4'(1 + ($urandom % 15));
    m.arm(1'b0, w, 1'b1);
    note_frame(1'b1, 1'b0, 1'b0, w);
    note_msg(11);
    note_frame(1'b1, 1'b0, 1'b1, 4'h0);
    irq_ext[11] = 1'b1;
    settle();
    give_verdict();
  end
endmodule : tb
